// *** design/gauge_sincos_pwm_driver.sv ***
/*
  Gauge driver top: serial command intake, quadrant continuity check,
  open-drain fault pin, power-on bridge self-test, gauge registers,
  two sine/cosine bridges and three direct-duty PWM outputs.
  Assumes serial pins already synchronous to i_mclk and an external
  analog sense comparator reporting open/short for the selected pair.
*/
// Contract
// - Self-test each bridge pair in turn, tri-stated
// - Fault low during test, then by result
// - Self-test lasts a fixed clock count
// - Bridges low until gauge value received
// - Serial data sampled on rising clock edge
// - Idle while select low; start bit one
// - Three opcode bits choose gauge one to five
// - Ten angle bits follow, MSB first
// - Two quadrant bits follow, MSB first
// - Error shown at falling edge after quadrant
// - Quadrant discontinuity on gauges 1,2 drives fault
// - Select fall releases fault, drops error
// - Next one bit restarts a fresh frame
// - Select fall stores valid, error-free write
// - Inhibit low stores despite quadrant error
// - Sine table 512x9, angle LSB dropped
// - Quadrant code picks 90-degree sector
// - Quadrant routes sine/cosine to bridge pins
// - PWM period is 512 clock cycles
// - Nine angle MSBs are direct duty
// - Three independent 90-degree PWM outputs
`timescale 1ns/1ns
`default_nettype none
module gauge_sincos_pwm_driver
  import gauge_pkg::*;
#(
  parameter int SELFTEST_CYCLES_P = gauge_pkg::SELFTEST_CYCLES
)
(
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_cs,
  input wire logic i_sclk,
  input wire logic i_din,
  input wire logic i_continuity_check_inhibit_n,
  input wire logic i_pair_sense_fault,
  output logic o_fault_out_n_o,
  output logic o_fault_out_n_oe,
  output logic o_bridge_oe,
  output logic [gauge_pkg::NUM_PAIRS-1:0] o_pair_sel,
  output logic o_g1_sine_plus,
  output logic o_g1_sine_minus,
  output logic o_g1_cosine_plus,
  output logic o_g1_cosine_minus,
  output logic o_g2_sine_plus,
  output logic o_g2_sine_minus,
  output logic o_g2_cosine_plus,
  output logic o_g2_cosine_minus,
  output logic o_gauge3_pwm_out,
  output logic o_gauge4_pwm_out,
  output logic o_gauge5_pwm_out
);
  import gauge_pkg::*;

  localparam int SLOT_CYCLES = SELFTEST_CYCLES_P / NUM_PAIRS;
  localparam int TW = $clog2(SLOT_CYCLES + 1);
  localparam logic [TW-1:0] SLOT_LAST = TW'(SLOT_CYCLES - 1);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  mode_e mode_reg;
  logic [TW-1:0] test_cnt_reg;
  logic [1:0] pair_reg;
  logic selftest_fail_reg;
  logic [PWM_BITS-1:0] pwm_cnt_reg;
  logic cs_reg;
  logic cs_fall;
  logic rx_done;
  logic rx_fall;
  logic [FRAME_BITS-1:0] rx_frame;
  logic [OP_BITS-1:0] rx_op;
  logic [ANGLE_BITS-1:0] rx_angle;
  logic [QUAD_BITS-1:0] rx_quad;
  logic op_valid;
  logic [2:0] op_gauge;
  logic frm_write_reg;
  logic [2:0] frm_gauge_reg;
  logic [ANGLE_BITS-1:0] frm_angle_reg;
  logic [QUAD_BITS-1:0] frm_quad_reg;
  logic err_reg;
  logic show_pend_reg;
  logic fault_serial_reg;
  logic [NUM_GAUGES-1:0][ANGLE_BITS-1:0] angle_reg;
  logic [1:0][QUAD_BITS-1:0] quad_reg;
  logic [NUM_GAUGES-1:0] loaded_reg;
  logic store_now;
  logic [1:0] bridge_sine_plus;
  logic [1:0] bridge_sine_minus;
  logic [1:0] bridge_cosine_plus;
  logic [1:0] bridge_cosine_minus;
  logic [2:0] direct_pwm;

  // Only one-step moves, or none, keep the pointer from spinning backwards
  function automatic logic quad_continuous(input logic [1:0] prev, input logic [1:0] nxt);
    return 2'(nxt - prev) != QUAD_OPPOSITE;
  endfunction

  serial_frame_rx u_rx (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_cs(i_cs),
    .i_sclk(i_sclk),
    .i_din(i_din),
    .o_done(rx_done),
    .o_sclk_fall(rx_fall),
    .o_frame(rx_frame)
  );

  assign rx_op = rx_frame[14:12];
  assign rx_angle = rx_frame[11:2];
  assign rx_quad = rx_frame[1:0];
  assign cs_fall = cs_reg & ~i_cs;

  always_comb
  begin
    op_valid = 1'b1;
    op_gauge = 3'h0;
    case (rx_op)
      OP_GAUGE1: op_gauge = 3'h0;
      OP_GAUGE2: op_gauge = 3'h1;
      OP_GAUGE3: op_gauge = 3'h2;
      OP_GAUGE4: op_gauge = 3'h3;
      OP_GAUGE5: op_gauge = 3'h4;
      default: op_valid = 1'b0;
    endcase
  end

  // Power-on self-test sequencer
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      mode_reg <= ST_TEST;
      test_cnt_reg <= '0;
      pair_reg <= 2'h0;
      selftest_fail_reg <= 1'b0;
    end
    else if (i_ce)
    begin
      case (mode_reg)
        ST_TEST:
        begin
          test_cnt_reg <= test_cnt_reg + TW'(1);
          if (test_cnt_reg == SLOT_LAST)
          begin
            test_cnt_reg <= '0;
            selftest_fail_reg <= selftest_fail_reg | i_pair_sense_fault;
            pair_reg <= pair_reg + 2'h1;
            if (pair_reg == 2'(NUM_PAIRS - 1))
              mode_reg <= ST_RUN;
          end
        end
        ST_RUN: mode_reg <= ST_RUN;
        default: mode_reg <= ST_TEST;
      endcase
    end
  end

  // Bridges tri-stated during test so the sense resistors see the coils
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_bridge_oe <= 1'b0;
      o_pair_sel <= '0;
    end
    else if (i_ce)
    begin
      o_bridge_oe <= (mode_reg == ST_RUN);
      o_pair_sel <= '0;
      if (mode_reg == ST_TEST)
        o_pair_sel[pair_reg] <= 1'b1;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      pwm_cnt_reg <= '0;
    else if (i_ce)
      pwm_cnt_reg <= pwm_cnt_reg + PWM_BITS'(1);
  end

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      cs_reg <= 1'b0;
    else if (i_ce)
      cs_reg <= i_cs;
  end

  // Frame capture and continuity check
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      frm_write_reg <= 1'b0;
      frm_gauge_reg <= 3'h0;
      frm_angle_reg <= ANGLE_RESET;
      frm_quad_reg <= QUAD_RESET;
      err_reg <= 1'b0;
    end
    else if (i_ce)
    begin
      if (rx_done && mode_reg == ST_RUN)
      begin
        frm_write_reg <= op_valid;
        frm_gauge_reg <= op_gauge;
        frm_angle_reg <= rx_angle;
        frm_quad_reg <= rx_quad;
        err_reg <= op_valid && op_gauge < 3'h2
                   && !quad_continuous(quad_reg[op_gauge[0]], rx_quad);
      end
      else if (cs_fall)
      begin
        frm_write_reg <= 1'b0;
        err_reg <= 1'b0;
      end
    end
  end

  // Error is presented at the first falling serial clock after the frame
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      show_pend_reg <= 1'b0;
      fault_serial_reg <= 1'b0;
    end
    else if (i_ce)
    begin
      if (rx_done && mode_reg == ST_RUN)
        show_pend_reg <= 1'b1;
      else if (rx_fall || cs_fall)
        show_pend_reg <= 1'b0;
      if (cs_fall)
        fault_serial_reg <= 1'b0;
      else if (rx_fall && show_pend_reg)
        fault_serial_reg <= err_reg;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_fault_out_n_o <= 1'b0;
      o_fault_out_n_oe <= 1'b1;
    end
    else if (i_ce)
    begin
      o_fault_out_n_o <= 1'b0;
      o_fault_out_n_oe <= (mode_reg == ST_TEST) | selftest_fail_reg
                          | fault_serial_reg;
    end
  end

  assign store_now = cs_fall && frm_write_reg
                     && (!err_reg || !i_continuity_check_inhibit_n);

  // Gauge registers
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      angle_reg <= '0;
      quad_reg <= '0;
      loaded_reg <= '0;
    end
    else if (i_ce && store_now)
    begin
      angle_reg[frm_gauge_reg] <= frm_angle_reg;
      loaded_reg[frm_gauge_reg] <= 1'b1;
      if (frm_gauge_reg < 3'h2)
        quad_reg[frm_gauge_reg[0]] <= frm_quad_reg;
    end
  end

  generate
    for (genvar g = 0; g < 2; g++)
    begin : bridge_gen
      sincos_pwm_chan u_chan (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_ce(i_ce),
        .i_run(loaded_reg[g] && mode_reg == ST_RUN),
        .i_pwm_cnt(pwm_cnt_reg),
        .i_angle(angle_reg[g]),
        .i_quad(quad_reg[g]),
        .o_sine_plus(bridge_sine_plus[g]),
        .o_sine_minus(bridge_sine_minus[g]),
        .o_cosine_plus(bridge_cosine_plus[g]),
        .o_cosine_minus(bridge_cosine_minus[g])
      );
    end
    for (genvar g = 0; g < 3; g++)
    begin : direct_gen
      always_ff @(posedge i_mclk or negedge i_rst_n)
      begin
        if (!i_rst_n)
          direct_pwm[g] <= 1'b0;
        else if (i_ce)
          direct_pwm[g] <= loaded_reg[g+2]
                           && pwm_cnt_reg < angle_reg[g+2][ANGLE_BITS-1:1];
      end
    end
  endgenerate

  assign o_g1_sine_plus = bridge_sine_plus[0];
  assign o_g1_sine_minus = bridge_sine_minus[0];
  assign o_g1_cosine_plus = bridge_cosine_plus[0];
  assign o_g1_cosine_minus = bridge_cosine_minus[0];
  assign o_g2_sine_plus = bridge_sine_plus[1];
  assign o_g2_sine_minus = bridge_sine_minus[1];
  assign o_g2_cosine_plus = bridge_cosine_plus[1];
  assign o_g2_cosine_minus = bridge_cosine_minus[1];
  assign o_gauge3_pwm_out = direct_pwm[0];
  assign o_gauge4_pwm_out = direct_pwm[1];
  assign o_gauge5_pwm_out = direct_pwm[2];

  test_fault_low_a: assert property (
    mode_reg == ST_TEST |-> o_fault_out_n_oe)
    else $error("fault pin released during self-test");
  test_tristate_a: assert property (
    mode_reg == ST_TEST |-> !o_bridge_oe)
    else $error("bridges driven during self-test");
  test_end_a: assert property (
    (i_ce && mode_reg == ST_TEST && test_cnt_reg == SLOT_LAST && pair_reg == 2'h3)
    |=> mode_reg == ST_RUN)
    else $error("self-test did not end on count");
  idle_low_a: assert property (
    $past(!loaded_reg[0]) |-> !(o_g1_sine_plus | o_g1_sine_minus
                                | o_g1_cosine_plus | o_g1_cosine_minus))
    else $error("gauge 1 bridge active before any value");
  pwm_wrap_a: assert property (
    (i_ce && pwm_cnt_reg == 9'h1FF) |=> pwm_cnt_reg == 9'h000)
    else $error("PWM period not 512 cycles");
  fault_release_a: assert property (
    (i_ce && cs_fall && mode_reg == ST_RUN && !selftest_fail_reg) ##1 i_ce
    |=> !o_fault_out_n_oe)
    else $error("fault pin not released after select fall");
  store_valid_a: assert property (
    (i_ce && cs_fall && frm_write_reg && !err_reg && frm_gauge_reg == 3'h2)
    |=> angle_reg[2] == $past(frm_angle_reg))
    else $error("valid write not stored");
  partial_drop_a: assert property (
    (cs_fall && !frm_write_reg) |=> $stable(angle_reg) && $stable(quad_reg))
    else $error("gauge register changed without full frame");
  error_show_a: assert property (
    (i_ce && rx_fall && show_pend_reg && err_reg && !cs_fall) ##1 i_ce
    |=> o_fault_out_n_oe)
    else $error("quadrant error not presented on fault pin");
  direct_duty_a: assert property (
    i_ce |=> o_gauge3_pwm_out == ($past(loaded_reg[2])
      && {1'b0, $past(pwm_cnt_reg)} < ($past(angle_reg[2]) >> 1)))
    else $error("gauge 3 duty mismatch");
endmodule
`default_nettype wire

// *** design/gauge_pkg.sv ***
/*
  Shared constants for the gauge driver: frame layout, operation codes,
  self-test timing, PWM width and the operating-mode encoding.
  Assumes one core clock; the self-test is a fixed count of its cycles.
*/
package gauge_pkg;
  localparam int SELFTEST_REF_MHZ = 8;
  localparam int SELFTEST_TIME_US = 4000;
  // Fixed cycle count, so the test shortens with a faster clock
  localparam int SELFTEST_CYCLES = SELFTEST_TIME_US * SELFTEST_REF_MHZ;
  localparam int NUM_PAIRS = 4;
  localparam int NUM_GAUGES = 5;
  localparam int PWM_BITS = 9;
  localparam int ANGLE_BITS = 10;
  localparam int QUAD_BITS = 2;
  localparam int OP_BITS = 3;
  localparam int FRAME_BITS = 15;
  localparam logic [3:0] FRAME_LAST = 4'hE;
  localparam logic [2:0] OP_GAUGE1 = 3'h1;
  localparam logic [2:0] OP_GAUGE2 = 3'h3;
  localparam logic [2:0] OP_GAUGE3 = 3'h4;
  localparam logic [2:0] OP_GAUGE4 = 3'h6;
  localparam logic [2:0] OP_GAUGE5 = 3'h5;
  localparam logic [1:0] QUAD_RESET = 2'h0;
  localparam logic [1:0] QUAD_OPPOSITE = 2'h2;
  localparam logic [9:0] ANGLE_RESET = 10'h000;
  localparam logic [8:0] SINE_FULL = 9'h1FF;
  localparam int SINE_HALF_TURN = 2048;
  localparam longint SINE_DEN_K = 5242880;
  typedef enum logic [1:0] {
    ST_TEST = 2'b01,
    ST_RUN = 2'b10
  } mode_e;
endpackage

// *** design/serial_frame_rx.sv ***
/*
  Three-wire serial frame receiver: start bit then 15 bits, sampled on
  the serial clock rising edge. Assumes all pins synchronous to i_mclk.
*/
`timescale 1ns/1ns
`default_nettype none
module serial_frame_rx
  import gauge_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_cs,
  input wire logic i_sclk,
  input wire logic i_din,
  output logic o_done,
  output logic o_sclk_fall,
  output logic [gauge_pkg::FRAME_BITS-1:0] o_frame
);
  import gauge_pkg::*;
  logic sclk_reg;
  logic busy_reg;
  logic [3:0] cnt_reg;
  logic sclk_rise;

  assign sclk_rise = i_sclk & ~sclk_reg;

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      sclk_reg <= 1'b0;
      o_sclk_fall <= 1'b0;
    end
    else if (i_ce)
    begin
      sclk_reg <= i_sclk;
      o_sclk_fall <= sclk_reg & ~i_sclk;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      busy_reg <= 1'b0;
      cnt_reg <= 4'h0;
      o_frame <= '0;
      o_done <= 1'b0;
    end
    else if (i_ce)
    begin
      o_done <= 1'b0;
      if (!i_cs)
        busy_reg <= 1'b0;
      else if (sclk_rise)
      begin
        if (!busy_reg)
        begin
          busy_reg <= i_din;
          cnt_reg <= 4'h0;
        end
        else
        begin
          o_frame <= {o_frame[FRAME_BITS-2:0], i_din};
          cnt_reg <= cnt_reg + 4'h1;
          if (cnt_reg == FRAME_LAST)
          begin
            busy_reg <= 1'b0;
            o_done <= 1'b1;
          end
        end
      end
    end
  end

  cs_idle_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (!i_cs && i_ce) |=> !busy_reg)
    else $error("receiver busy with chip select low");
endmodule
`default_nettype wire

// *** design/sincos_pwm_chan.sv ***
/*
  One 360-degree gauge: sine table, sine/cosine duty compare and
  quadrant routing to four bridge pins. Assumes a shared PWM counter.
*/
`timescale 1ns/1ns
`default_nettype none
module sincos_pwm_chan
  import gauge_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_run,
  input wire logic [gauge_pkg::PWM_BITS-1:0] i_pwm_cnt,
  input wire logic [gauge_pkg::ANGLE_BITS-1:0] i_angle,
  input wire logic [gauge_pkg::QUAD_BITS-1:0] i_quad,
  output logic o_sine_plus,
  output logic o_sine_minus,
  output logic o_cosine_plus,
  output logic o_cosine_minus
);
  import gauge_pkg::*;
  localparam int ROM_DEPTH = 2 ** PWM_BITS;
  logic [PWM_BITS-1:0] sine_rom [ROM_DEPTH];
  logic [PWM_BITS-1:0] idx;
  logic [PWM_BITS-1:0] sine_duty;
  logic [PWM_BITS-1:0] cosine_duty;
  logic sine_pwm;
  logic cosine_pwm;

  // Rational sine fit; keeps the table as constants with no file to load
  function automatic logic [8:0] sine_val(input int i);
    longint x;
    longint num;
    longint den;
    x = 2 * longint'(i); // Two fit steps per entry, so 512 entries span a quarter turn
    num = 4 * x * (SINE_HALF_TURN - x);
    den = SINE_DEN_K - x * (SINE_HALF_TURN - x);
    return 9'((num * 511) / den);
  endfunction

  generate
    for (genvar g = 0; g < ROM_DEPTH; g++)
    begin : rom_gen
      assign sine_rom[g] = sine_val(g);
    end
  endgenerate

  assign idx = i_angle[ANGLE_BITS-1:1];
  assign sine_duty = sine_rom[idx];
  assign cosine_duty = (idx == '0) ? SINE_FULL : sine_rom[9'(10'h200 - {1'b0, idx})];
  assign sine_pwm = i_pwm_cnt < sine_duty;
  assign cosine_pwm = i_pwm_cnt < cosine_duty;

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      {o_sine_plus, o_sine_minus, o_cosine_plus, o_cosine_minus} <= 4'h0;
    else if (i_ce)
    begin
      {o_sine_plus, o_sine_minus, o_cosine_plus, o_cosine_minus} <= 4'h0;
      if (i_run)
        case (i_quad)
          2'h0: {o_sine_plus, o_cosine_plus} <= {sine_pwm, cosine_pwm};
          2'h1: {o_sine_plus, o_cosine_minus} <= {cosine_pwm, sine_pwm};
          2'h2: {o_sine_minus, o_cosine_minus} <= {sine_pwm, cosine_pwm};
          default: {o_sine_minus, o_cosine_plus} <= {cosine_pwm, sine_pwm};
        endcase
    end
  end

  quad_route_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (i_ce && i_run && i_quad == 2'h0) |=> (!o_sine_minus && !o_cosine_minus))
    else $error("minus pins active in first quadrant");
endmodule
`default_nettype wire

// *** tb/serial_host_model.sv ***
/*
  Host side of the three-wire link: drives select, serial clock and data,
  and samples the open-drain fault pin after each frame.
  Assumes a pull-up on the fault pin and a core clock at i_mclk.
*/
`timescale 1ns/1ns
`default_nettype none
module serial_host_model (
  input wire logic i_mclk,
  input wire logic i_fault_pin,
  output logic o_cs,
  output logic o_sclk,
  output logic o_din
);
  logic fault_seen_reg;

  initial
  begin
    o_cs = 1'b0;
    o_sclk = 1'b0;
    o_din = 1'b0;
    fault_seen_reg = 1'b1;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(negedge i_mclk);
  endtask

  // Serial clock only moves inside a frame, two core cycles per phase
  task automatic send_bits(input logic [15:0] bits, input int nbits);
    if (!o_cs)
    begin
      o_cs = 1'b1;
      wait_clk(2);
    end
    for (int k = 15; k > 15 - nbits; k--)
    begin
      o_din = bits[k];
      wait_clk(2);
      o_sclk = 1'b1;
      wait_clk(2);
      o_sclk = 1'b0;
    end
    wait_clk(4);
    fault_seen_reg = i_fault_pin;
  endtask

  // Released data line shows the inverse, not a stale bit
  task automatic end_select();
    wait_clk(1);
    o_cs = 1'b0;
    o_din = ~o_din;
    wait_clk(4);
  endtask
endmodule
`default_nettype wire

// *** tb/test_gauge_sincos_pwm_driver.sv ***
/*
  Self-checking bench for the gauge driver: self-test, direct duty,
  quadrant routing, continuity errors, inhibit and frame discards.
  Assumes the host model file and a shortened 40-cycle self-test.
*/
`timescale 1ns/1ns
`default_nettype none
module test_gauge_sincos_pwm_driver;
  import gauge_pkg::*;
  localparam int ST = 40;
  logic i_mclk = 1'b0;
  logic i_rst_n = 1'b0;
  logic inhibit_n = 1'b1;
  logic sense = 1'b0;
  logic cs, sclk, din, fault_o, fault_oe, bridge_oe;
  logic [NUM_PAIRS-1:0] pair_sel;
  logic [10:0] sv;
  wire logic [10:0] outs;
  int cnt[11];
  int miscompares = 0;
  int compares = 0;
  // Pull-up holds the pin high when released
  wire logic fault_pin = fault_oe ? fault_o : 1'b1;

  always #2 i_mclk = ~i_mclk;

  gauge_sincos_pwm_driver #(.SELFTEST_CYCLES_P(ST)) gauge_sincos_pwm_driver_i (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ce(1'b1), .i_cs(cs), .i_sclk(sclk),
    .i_din(din), .i_continuity_check_inhibit_n(inhibit_n), .i_pair_sense_fault(sense),
    .o_fault_out_n_o(fault_o), .o_fault_out_n_oe(fault_oe), .o_bridge_oe(bridge_oe),
    .o_pair_sel(pair_sel), .o_g1_sine_plus(outs[10]), .o_g1_sine_minus(outs[9]),
    .o_g1_cosine_plus(outs[8]), .o_g1_cosine_minus(outs[7]),
    .o_g2_sine_plus(outs[6]), .o_g2_sine_minus(outs[5]),
    .o_g2_cosine_plus(outs[4]), .o_g2_cosine_minus(outs[3]),
    .o_gauge3_pwm_out(outs[2]), .o_gauge4_pwm_out(outs[1]), .o_gauge5_pwm_out(outs[0]));

  serial_host_model serial_host_model_i (
    .i_mclk(i_mclk), .i_fault_pin(fault_pin), .o_cs(cs), .o_sclk(sclk), .o_din(din));

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic end_sim();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  function automatic logic [15:0] frm(input logic [2:0] op, input logic [9:0] a,
                                      input logic [1:0] q);
    return {1'b1, op, a, q};
  endfunction

  // One full 512-cycle period, so counts do not depend on phase
  task automatic measure();
    foreach (cnt[j]) cnt[j] = 0;
    repeat (512)
    begin
      @(negedge i_mclk);
      foreach (cnt[j]) if (outs[j] === 1'b1) cnt[j]++;
    end
    foreach (cnt[j]) sv[j] = (cnt[j] > 0);
  endtask

  task automatic wr(input logic [2:0] op, input logic [9:0] a, input logic [1:0] q);
    serial_host_model_i.send_bits(frm(op, a, q), 16);
    serial_host_model_i.end_select();
  endtask

  task automatic do_reset(input logic fail);
    @(negedge i_mclk);
    i_rst_n = 1'b0;
    sense = fail;
    repeat (5) @(negedge i_mclk);
    i_rst_n = 1'b1;
  endtask

  task automatic t_selftest(input logic fail);
    for (int k = 0; k < NUM_PAIRS; k++)
    begin
      repeat (k == 0 ? 5 : 10) @(negedge i_mclk);
      chk("pair_sel", 16'(1 << k), 16'(pair_sel));
      chk("test_flags", 16'h0001, {14'h0, bridge_oe, fault_oe});
    end
    repeat (15) @(negedge i_mclk);
    chk("end_flags", {14'h0, 1'b1, fail}, {14'h0, bridge_oe, fault_oe});
    if (!fail)
    begin
      measure();
      chk("idle_outs", 16'h0000, 16'(sv));
    end
    $display("test selftest done");
  endtask

  task automatic t_direct();
    wr(OP_GAUGE3, 10'h3FF, 2'h3);
    wr(OP_GAUGE4, 10'h001, 2'h1);
    wr(OP_GAUGE5, 10'h0A7, 2'h2);
    measure();
    chk("g3_duty", 16'h01FF, 16'(cnt[2]));
    chk("g4_duty", 16'h0000, 16'(cnt[1]));
    chk("g5_duty", 16'h0053, 16'(cnt[0]));
    chk("g12_idle", 16'h0000, 16'(sv[10:3]));
    $display("test direct done");
  endtask

  task automatic t_discard();
    logic [2:0] rsv[3];
    rsv = '{3'h0, 3'h2, 3'h7};
    foreach (rsv[j])
    begin
      serial_host_model_i.send_bits(frm(rsv[j], 10'h000, 2'h2), 16);
      chk("rsv_fault", 16'h0000, 16'(fault_oe));
      chk("rsv_pin", 16'h0001, 16'(serial_host_model_i.fault_seen_reg));
      serial_host_model_i.end_select();
    end
    serial_host_model_i.send_bits(frm(OP_GAUGE3, 10'h000, 2'h0), 10);
    serial_host_model_i.end_select();
    measure();
    chk("g3_kept", 16'h01FF, 16'(cnt[2]));
    chk("g5_kept", 16'h0053, 16'(cnt[0]));
    $display("test discard done");
  endtask

  task automatic t_quad();
    logic [1:0] q;
    logic [3:0] route[4];
    route = '{4'hA, 4'h9, 4'h5, 4'h6};
    for (int k = 1; k <= 4; k++)
    begin
      q = 2'(k);
      wr(OP_GAUGE1, 10'h100, q);
      measure();
      chk("g1_route", 16'(route[q]), 16'(sv[10:7]));
    end
    // Last pass: quadrant 0 at 22.5 degrees, about 511*sin and 511*cos
    chk("sine_duty", 16'h0001, 16'(cnt[10] > 192 && cnt[10] < 200));
    chk("cosine_duty", 16'h0001, 16'(cnt[8] > 468 && cnt[8] < 476));
    serial_host_model_i.send_bits(frm(OP_GAUGE1, 10'h100, 2'h2), 16);
    chk("err_shown", 16'h0001, 16'(fault_oe));
    chk("err_pin", 16'h0000, 16'(serial_host_model_i.fault_seen_reg));
    serial_host_model_i.send_bits(frm(OP_GAUGE1, 10'h100, 2'h1), 16);
    chk("err_retry", 16'h0000, 16'(fault_oe));
    serial_host_model_i.end_select();
    measure();
    chk("retry_store", 16'h0009, 16'(sv[10:7]));
    serial_host_model_i.send_bits(frm(OP_GAUGE1, 10'h100, 2'h3), 16);
    chk("err_shown2", 16'h0001, 16'(fault_oe));
    serial_host_model_i.end_select();
    chk("err_release", 16'h0000, 16'(fault_oe));
    measure();
    chk("err_kept", 16'h0009, 16'(sv[10:7]));
    $display("test quadrant done");
  endtask

  task automatic t_inhibit();
    @(negedge i_mclk);
    inhibit_n = 1'b0;
    wr(OP_GAUGE2, 10'h100, 2'h0);
    serial_host_model_i.send_bits(frm(OP_GAUGE2, 10'h100, 2'h2), 16);
    chk("inh_fault", 16'h0001, 16'(fault_oe));
    serial_host_model_i.end_select();
    measure();
    chk("inh_store", 16'h0005, 16'(sv[6:3]));
    inhibit_n = 1'b1;
    $display("test inhibit done");
  endtask

  initial
  begin
    do_reset(1'b0);
    t_selftest(1'b0);
    t_direct();
    t_discard();
    t_quad();
    t_inhibit();
    do_reset(1'b1);
    t_selftest(1'b1);
    end_sim();
  end

  // Hang guard
  initial
  begin
    repeat (100000) @(posedge i_mclk);
    miscompares++;
    end_sim();
  end
endmodule
`default_nettype wire
